// ===== design/osc_tick.sv
// Turns the slow watchdog oscillator into one-cycle ticks on clk
// Assumes clk runs far faster than the oscillator (at least 4x)
`timescale 1ns/1ps

module osc_tick (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Oscillator pin
  input wire logic osc_in,
  // Tick on each rising oscillator edge
  output logic tick
);

  logic meta;
  logic sync;
  logic sync_d;

  // Two flops before anything looks at the oscillator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= osc_in;
      sync <= meta;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_d <= 1'b0;
      tick <= 1'b0;
    end else begin
      sync_d <= sync;
      tick <= sync & ~sync_d;
    end
  end

endmodule

// ===== design/watchdog_downcounter_unlock.sv
// Watchdog down-counter with reload unlock sequence and reset-status flags
// Assumes register accesses come from logic on clk; the oscillator pin is
// asynchronous and the option bits are stable after reset.
`timescale 1ns/1ps
`include "watchdog_params.svh"

module watchdog_downcounter_unlock (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watchdog oscillator pin
  input wire logic wdt_osc,
  // CPU side
  input wire logic watchdog_refresh,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire watchdog_pkg::wdt_cfg_s cfg,
  input wire watchdog_pkg::reg_req_s req,
  output logic [7:0] rdata,
  // State and time-out consequences
  output logic wdt_enabled,
  output watchdog_pkg::wdt_event_s events
);

  logic tick;
  logic [23:0] count;
  logic [7:0] reload_upper_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] reload_low_byte;
  logic [23:0] reload_value;
  watchdog_pkg::lock_e lock_state;
  watchdog_pkg::lock_e next_lock_state;
  logic wdt_flag;
  logic stop_flag;
  logic start;
  logic refresh_ok;
  logic timeout;
  logic status_read;

  function automatic logic wr_to(input watchdog_pkg::reg_req_s r, input logic [11:0] a);
    wr_to = r.wr && (r.addr == a);
  endfunction

  function automatic logic rd_of(input watchdog_pkg::reg_req_s r, input logic [11:0] a);
    rd_of = r.rd && (r.addr == a);
  endfunction

  // Oscillator edge detection lives in the clk domain
  osc_tick u_tick (
    .clk(clk),
    .rst(rst),
    .osc_in(wdt_osc),
    .tick(tick)
  );

  assign reload_value = {reload_upper_byte, reload_high_byte, reload_low_byte};

  // Always-on takes effect on the first edge after reset release
  assign start = !wdt_enabled && (watchdog_refresh || cfg.always_on_option);
  // Near the end the refresh is refused so a due time-out cannot be dodged
  assign refresh_ok = watchdog_refresh && (count > `WDT_CNT_NO_REFRESH);
  // Time-out is the step from 1 to 0; debug mode never gets there
  assign timeout = wdt_enabled && tick && !debug_mode && (count == `WDT_CNT_LAST);
  assign status_read = rd_of(req, `WDT_ADDR_UNLOCK);

  // Enable has only on and off; nothing turns it off but reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_enabled <= 1'b0;
    end else if (start) begin
      wdt_enabled <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= `WDT_CNT_MAX;
    end else if (!wdt_enabled) begin
      if (start) begin
        count <= reload_value;
      end
    end else if (debug_mode) begin
      count <= reload_value;
    end else if (refresh_ok) begin
      count <= reload_value;
    end else if (tick) begin
      // From zero this rolls to all ones rather than reloading
      count <= count - 24'h000001;
    end
  end

  // Lock sequencer: a register write anywhere that does not advance it relocks it, save a repeated first key
  always_comb begin
    next_lock_state = lock_state;
    if (req.wr) begin
      next_lock_state = watchdog_pkg::lock_locked;
      case (lock_state)
        watchdog_pkg::lock_locked: begin
          if (wr_to(req, `WDT_ADDR_UNLOCK) && req.wdata == `WDT_KEY_FIRST) begin
            next_lock_state = watchdog_pkg::lock_got_first;
          end
        end
        watchdog_pkg::lock_got_first: begin
          if (wr_to(req, `WDT_ADDR_UNLOCK) && req.wdata == `WDT_KEY_SECOND) begin
            next_lock_state = watchdog_pkg::lock_open;
          end else if (wr_to(req, `WDT_ADDR_UNLOCK) && req.wdata == `WDT_KEY_FIRST) begin
            next_lock_state = watchdog_pkg::lock_got_first;
          end
        end
        watchdog_pkg::lock_open: begin
          if (wr_to(req, `WDT_ADDR_UPPER)) begin
            next_lock_state = watchdog_pkg::lock_upper_done;
          end
        end
        watchdog_pkg::lock_upper_done: begin
          if (wr_to(req, `WDT_ADDR_HIGH)) begin
            next_lock_state = watchdog_pkg::lock_high_done;
          end
        end
        watchdog_pkg::lock_high_done: begin
          next_lock_state = watchdog_pkg::lock_locked;
        end
        default: begin
          next_lock_state = watchdog_pkg::lock_locked;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_state <= watchdog_pkg::lock_locked;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  // Reload bytes change only in their own step of the sequence.
  // Values under 4 are not guarded here; software keeps to that floor.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_upper_byte <= `WDT_RST_UPPER;
      reload_high_byte <= `WDT_RST_HIGH;
      reload_low_byte <= `WDT_RST_LOW;
    end else begin
      if (lock_state == watchdog_pkg::lock_open && wr_to(req, `WDT_ADDR_UPPER)) begin
        reload_upper_byte <= req.wdata;
      end
      if (lock_state == watchdog_pkg::lock_upper_done && wr_to(req, `WDT_ADDR_HIGH)) begin
        reload_high_byte <= req.wdata;
      end
      if (lock_state == watchdog_pkg::lock_high_done && wr_to(req, `WDT_ADDR_LOW)) begin
        reload_low_byte <= req.wdata;
      end
    end
  end

  // Status flags survive the system reset they request; only rst clears them
  // besides a status read. A new event in the read cycle wins over the clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_flag <= 1'b0;
    end else if (timeout) begin
      wdt_flag <= 1'b1;
    end else if (status_read) begin
      wdt_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_flag <= 1'b0;
    end else if (timeout && stop_mode) begin
      stop_flag <= 1'b1;
    end else if (status_read) begin
      stop_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      events <= '0;
    end else begin
      events.irq_req <= timeout && !cfg.timeout_response_option;
      events.sys_reset_req <= timeout && cfg.timeout_response_option && !stop_mode;
      events.stop_recovery <= timeout && stop_mode;
    end
  end

  // Read data: status at the shared address, live count on the reload bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      if (req.addr == `WDT_ADDR_UNLOCK) begin
        rdata <= 8'h00;
        rdata[`WDT_STAT_WDT_BIT] <= wdt_flag;
        rdata[`WDT_STAT_STOP_BIT] <= stop_flag;
      end else if (req.addr == `WDT_ADDR_UPPER) begin
        rdata <= count[23:16];
      end else if (req.addr == `WDT_ADDR_HIGH) begin
        rdata <= count[15:8];
      end else if (req.addr == `WDT_ADDR_LOW) begin
        rdata <= count[7:0];
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  a_load_on_enable: assert property (@(posedge clk) disable iff (rst)
    !wdt_enabled ##1 wdt_enabled |-> count == $past(reload_value))
    else $error("counter not loaded from reload value at enable");

  a_always_on_start: assert property (@(posedge clk) disable iff (rst)
    cfg.always_on_option |=> wdt_enabled)
    else $error("always-on option did not enable watchdog");

  a_refresh_reloads: assert property (@(posedge clk) disable iff (rst)
    wdt_enabled && watchdog_refresh && count > `WDT_CNT_NO_REFRESH |=> count == $past(reload_value))
    else $error("refresh did not reload counter");

  a_refresh_refused: assert property (@(posedge clk) disable iff (rst)
    wdt_enabled && watchdog_refresh && !debug_mode && !tick && count <= `WDT_CNT_NO_REFRESH
    |=> count == $past(count))
    else $error("late refresh was not ignored");

  a_debug_refresh: assert property (@(posedge clk) disable iff (rst)
    wdt_enabled && debug_mode |=> count == $past(reload_value) && !events.irq_req ##1 !events.irq_req)
    else $error("debug mode did not hold counter at reload");

  a_wrap_all_ones: assert property (@(posedge clk) disable iff (rst)
    wdt_enabled && tick && count == `WDT_CNT_ZERO && !debug_mode && !watchdog_refresh
    |=> count == `WDT_CNT_MAX)
    else $error("counter did not wrap to all ones");

  a_irq_timeout: assert property (@(posedge clk) disable iff (rst)
    timeout && !cfg.timeout_response_option |=> events.irq_req && wdt_flag && !events.sys_reset_req)
    else $error("interrupt time-out missing request or flag");

  a_reset_timeout: assert property (@(posedge clk) disable iff (rst)
    timeout && cfg.timeout_response_option && !stop_mode |=> events.sys_reset_req && wdt_flag
    && !events.stop_recovery)
    else $error("reset time-out missing reset request");

  a_stop_recovery: assert property (@(posedge clk) disable iff (rst)
    timeout && stop_mode |=> events.stop_recovery && wdt_flag && stop_flag && !events.sys_reset_req)
    else $error("stop time-out missing recovery or flags");

  a_status_clear: assert property (@(posedge clk) disable iff (rst)
    status_read && !timeout |=> !wdt_flag ##1 rdata == 8'h00 || !$past(status_read))
    else $error("status read did not clear watchdog flag");

  a_locked_write: assert property (@(posedge clk) disable iff (rst)
    lock_state == watchdog_pkg::lock_locked && wr_to(req, `WDT_ADDR_UPPER)
    |=> reload_upper_byte == $past(reload_upper_byte))
    else $error("locked reload byte was written");

  a_relock_after_low: assert property (@(posedge clk) disable iff (rst)
    lock_state == watchdog_pkg::lock_high_done && wr_to(req, `WDT_ADDR_LOW)
    |=> lock_state == watchdog_pkg::lock_locked && reload_low_byte == $past(req.wdata))
    else $error("low byte write did not store and relock");

endmodule

// ===== include/watchdog_params.svh
// Offsets, field positions, reset values and compare points of the watchdog
// Assumes a 12-bit register address space with 8-bit registers
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

`define WDT_ADDR_W 12
`define WDT_CNT_W 24

// Register addresses
`define WDT_ADDR_UNLOCK 12'hff0
`define WDT_ADDR_UPPER 12'hff1
`define WDT_ADDR_HIGH 12'hff2
`define WDT_ADDR_LOW 12'hff3

// Reload byte reset values
`define WDT_RST_UPPER 8'h00
`define WDT_RST_HIGH 8'h04
`define WDT_RST_LOW 8'h00

// Unlock keys
`define WDT_KEY_FIRST 8'h55
`define WDT_KEY_SECOND 8'haa

// Reset-status field positions
`define WDT_STAT_WDT_BIT 5
`define WDT_STAT_STOP_BIT 4

// Counter compare points
`define WDT_CNT_NO_REFRESH 24'h000002
`define WDT_CNT_LAST 24'h000001
`define WDT_CNT_ZERO 24'h000000
`define WDT_CNT_MAX 24'hffffff

`endif

// ===== include/watchdog_pkg.sv
// Types shared by the watchdog design
// Assumes watchdog_params.svh is on the include path
package watchdog_pkg;

  typedef enum logic [2:0] {
    lock_locked = 3'b000,
    lock_got_first = 3'b001,
    lock_open = 3'b010,
    lock_upper_done = 3'b011,
    lock_high_done = 3'b100
  } lock_e;

  // One register access from the CPU; wr and rd are one-cycle strobes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Nonvolatile option bits, stable while running
  typedef struct packed {
    logic always_on_option;
    logic timeout_response_option;
  } wdt_cfg_s;

  // Time-out consequences, one-cycle pulses
  typedef struct packed {
    logic irq_req;
    logic sys_reset_req;
    logic stop_recovery;
  } wdt_event_s;

endpackage

// ===== tb/watchdog_downcounter_unlock_test.sv
// Self-checking bench for the watchdog down-counter with reload unlock
// Assumes a 100 MHz clk and an oscillator period of twenty clk cycles
`timescale 1ns/1ps
`include "watchdog_params.svh"

module watchdog_downcounter_unlock_test;
  logic clk;
  logic rst;
  logic wdt_osc;
  logic watchdog_refresh;
  logic debug_mode;
  logic stop_mode;
  watchdog_pkg::wdt_cfg_s cfg;
  watchdog_pkg::reg_req_s req;
  logic [7:0] rdata;
  logic wdt_enabled;
  watchdog_pkg::wdt_event_s events;
  logic [2:0] ev;
  logic [7:0] d;
  logic [7:0] seed;
  logic [23:0] v;
  int n_fail;
  int compares;
  int waited;
  logic [23:0] m_reload;

  wdt_osc_model #(.half_ns(100)) u_wdt_osc_model (.osc(wdt_osc));

  watchdog_downcounter_unlock u_watchdog_downcounter_unlock (
    .clk(clk), .rst(rst), .wdt_osc(wdt_osc), .watchdog_refresh(watchdog_refresh),
    .debug_mode(debug_mode), .stop_mode(stop_mode), .cfg(cfg), .req(req),
    .rdata(rdata), .wdt_enabled(wdt_enabled), .events(events));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = x;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] x);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    x = rdata;
  endtask

  task automatic refresh();
    @(negedge clk);
    watchdog_refresh = 1'b1;
    @(negedge clk);
    watchdog_refresh = 1'b0;
  endtask

  // Software never asks for a reload below four
  task automatic set_reload(input logic [23:0] x);
    wr(`WDT_ADDR_UNLOCK, `WDT_KEY_FIRST);
    wr(`WDT_ADDR_UNLOCK, `WDT_KEY_SECOND);
    wr(`WDT_ADDR_UPPER, x[23:16]);
    wr(`WDT_ADDR_HIGH, x[15:8]);
    wr(`WDT_ADDR_LOW, x[7:0]);
    m_reload = x;
  endtask

  task automatic do_reset(input logic ao, input logic mode);
    @(negedge clk);
    rst = 1'b1;
    cfg.always_on_option = ao;
    cfg.timeout_response_option = mode;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    m_reload = 24'h000400;
  endtask

  // Bounded wait for a time-out pulse, then confirm it lasted one cycle
  task automatic wait_ev(input int limit);
    ev = 3'b000;
    waited = 0;
    while ((|ev) !== 1'b1 && waited < limit) begin
      @(negedge clk);
      ev = events;
      waited++;
    end
    if ((|ev) !== 1'b1) begin
      n_fail++;
      $display("unexpected wait: no time-out event within %0d cycles", limit);
      conclude();
    end else begin
      @(negedge clk);
      check("event pulse width", 24'(events), 24'h0);
    end
  endtask

  initial begin
    rst = 1'b1;
    req = '0;
    cfg = '0;
    watchdog_refresh = 1'b0;
    debug_mode = 1'b0;
    stop_mode = 1'b0;
    n_fail = 0;
    compares = 0;
    seed = 8'h60;
    do_reset(1'b0, 1'b0);
    check("enabled after reset", 24'(wdt_enabled), 24'h0);
    rd(`WDT_ADDR_UNLOCK, d);
    check("status after reset", 24'(d), 24'h0);
    rd(12'h100, d);
    check("unmapped read", 24'(d), 24'h0);
    // A foreign write between key and upper byte must block the upper byte
    seed = lfsr(seed);
    wr(`WDT_ADDR_UNLOCK, `WDT_KEY_FIRST);
    wr(`WDT_ADDR_UNLOCK, `WDT_KEY_SECOND);
    wr(12'h100, 8'h00);
    wr(`WDT_ADDR_UPPER, seed);
    refresh();
    check("enabled by refresh", 24'(wdt_enabled), 24'h1);
    rd(`WDT_ADDR_UPPER, d);
    check("upper after broken sequence", 24'(d), 24'(m_reload[23:16]));
    // Random reload, low byte kept large so upper and high stay put
    seed = lfsr(seed);
    v[23:16] = seed;
    seed = lfsr(seed);
    v[15:0] = {seed, 8'hf0};
    // Stands in for a scaled calibration value chosen by software
    set_reload(v);
    rd(`WDT_ADDR_UNLOCK, d);
    check("keys not stored", 24'(d), 24'h0);
    refresh();
    rd(`WDT_ADDR_UPPER, d);
    check("count upper byte", 24'(d), 24'(m_reload[23:16]));
    rd(`WDT_ADDR_HIGH, d);
    check("count high byte", 24'(d), 24'(m_reload[15:8]));
    wr(`WDT_ADDR_HIGH, ~v[15:8]);
    refresh();
    rd(`WDT_ADDR_HIGH, d);
    check("high after relock", 24'(d), 24'(m_reload[15:8]));
    // Every response mode, in and out of STOP
    for (int i = 0; i < 4; i++) begin
      do_reset(1'b0, i[0]);
      stop_mode = i[1];
      set_reload(24'h000004);
      refresh();
      wait_ev(400);
      check("time-out event", 24'(ev), 24'({~i[0], i[0] & ~i[1], i[1]}));
      rd(`WDT_ADDR_UNLOCK, d);
      check("status after time-out", 24'(d), 24'({2'b00, 1'b1, i[1], 4'h0}));
      rd(`WDT_ADDR_UNLOCK, d);
      check("status after read", 24'(d), 24'h0);
      // The roll-over from zero waits for the next oscillator tick
      repeat (20) @(negedge clk);
      rd(`WDT_ADDR_UPPER, d);
      check("count after wrap", 24'(d), 24'hff);
    end
    stop_mode = 1'b0;
    // A refresh once the count shows two must not delay the time-out
    do_reset(1'b0, 1'b0);
    set_reload(24'h000004);
    refresh();
    d = 8'hff;
    waited = 0;
    while (d !== 8'h02 && waited < 100) begin
      rd(`WDT_ADDR_LOW, d);
      waited++;
    end
    check("count reached two", 24'(d), 24'h2);
    refresh();
    wait_ev(50);
    check("late refresh event", 24'(ev), 24'h4);
    // Debug mode keeps reloading, so no event may appear
    do_reset(1'b0, 1'b0);
    set_reload(24'h000004);
    refresh();
    debug_mode = 1'b1;
    waited = 0;
    repeat (200) begin
      @(negedge clk);
      if (events !== 3'b000) waited++;
    end
    check("events in debug", 24'(waited), 24'h0);
    debug_mode = 1'b0;
    wait_ev(200);
    check("event after debug", 24'(ev), 24'h4);
    // Always-on starts at the first edge after reset with the reset reload
    do_reset(1'b1, 1'b0);
    @(negedge clk);
    check("always-on enable", 24'(wdt_enabled), 24'h1);
    rd(`WDT_ADDR_UPPER, d);
    check("always-on load", 24'(d), 24'(m_reload[23:16]));
    conclude();
  end
endmodule

// ===== tb/wdt_osc_model.sv
// Free-running model of the watchdog RC oscillator
// Assumes the bench clock runs at least four times faster than this
`timescale 1ns/1ps

module wdt_osc_model #(
  parameter int half_ns = 100
) (
  // Oscillator output
  output logic osc
);
  // Offset keeps its edges clear of the system clock edges
  initial begin
    osc = 1'b0;
    #3;
    forever #(half_ns) osc = ~osc;
  end
endmodule
